/* dv/test_uhp_port.sv */
/* Bench of uhp_port with the host model. Assumes one 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module test_uhp_port;
  import uhp_pkg::*;
  logic       clk = 0, rst = 1, dvn = 0, role = 0, cm = 0, csn, rdn, wrn, ps, ackn, oe, oed = 0, irq, rqn, slv, c12;
  logic [6:0] ev = 0;
  logic [7:0] din, dq, e, m [4], q [$];
  int         bad_count = 0, checks = 0;
  always #5 clk = ~clk;
  uhp_host_model host (.i_clk(clk), .i_req_n(rqn), .o_cs_n(csn), .o_rd_n(rdn), .o_wr_n(wrn), .o_ps(ps),
    .o_ack_n(ackn), .o_data(din));
  uhp_port dut (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1), .I_DEVICE_RESET_N(dvn), .I_CHIP_SELECT_N(csn),
    .I_READ_STROBE_N(rdn), .I_WRITE_STROBE_N(wrn), .I_PORT_SELECT(ps), .I_DATA(din), .O_DATA(dq),
    .O_DATA_OE(oe), .O_IRQ_OUT(irq), .I_ROLE_STRAP(role), .I_CLOCK_MULTIPLY_SELECT(cm), .I_DMA_ACK_N(ackn),
    .O_DMA_REQ_N(rqn), .I_EVENTS(ev), .O_SLAVE_MODE(slv), .O_CLK_12M_SRC(c12));
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %0t %h %h", $time, s, x);
    end
  endtask
  task automatic poke(input logic [7:0] a, input logic [7:0] d);
    host.cyc(1'b0, 1'b0, a);
    host.cyc(1'b0, 1'b1, d);
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] x);
    q.push_back(x);
    host.cyc(1'b0, 1'b0, a);
    host.cyc(1'b1, 1'b1, 8'h00);
  endtask
  always @(posedge clk) begin
    oed <= oe;
    if (oe && !oed) chk(dq, q.pop_front());
  end
  task automatic complete_run;
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'he5cc5641));
    cm <= 1'($urandom);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    dvn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m[i] = 8'($urandom);
      poke(8'h40 + 8'(i), m[i]);
    end
    for (int i = 0; i < 4; i++) peek(8'h40 + 8'(i), m[i]);
    e = 8'($urandom) & IST_EVT_MASK | 8'h01;
    @(posedge clk) ev <= e[6:0];
    @(posedge clk) ev <= 7'h00;
    repeat (2) @(posedge clk);
    chk(8'(irq), 8'h01);
    chk(8'(c12), 8'(cm));
    peek(INT_STAT_ADDR, e);
    m[0] = 8'($urandom);
    poke(INT_STAT_ADDR, m[0]);
    peek(INT_STAT_ADDR, e & ~m[0] & IST_EVT_MASK);
    poke(INT_STAT_ADDR, 8'hff);
    chk(8'(irq), 8'h00);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk) role <= r[0];
      poke(CTRL1_ADDR, 8'(1 << CTRL1_DMA_EN));
      poke(DMA_CNT_LO, 8'($urandom_range(4, 1)));
      poke(DMA_CNT_HI, 8'h00);
      repeat (40) @(posedge clk);
      chk(8'(slv), 8'(r));
      peek(INT_STAT_ADDR, 8'(r << IST_DMA_DONE));
      poke(INT_STAT_ADDR, 8'hff);
    end
    complete_run;
  end
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule // test_uhp_port
`default_nettype wire

/* dv/uhp_host_model.sv */
/* Host processor and DMA controller model. Assumes the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module uhp_host_model (
  input  wire logic       i_clk, i_req_n,
  output logic            o_cs_n, o_rd_n, o_wr_n, o_ps, o_ack_n,
  output logic      [7:0] o_data
);
  initial {o_cs_n, o_rd_n, o_wr_n, o_ps, o_ack_n, o_data} = 13'h1fff;
  // One acknowledge per request; with no request, as in master, it stays high.
  always @(posedge i_clk) o_ack_n <= !(o_ack_n && !i_req_n);
  // One strobe pulse held two edges; a released bus shows the inverse value.
  task automatic cyc(input logic rd, input logic ps, input logic [7:0] d);
    @(posedge i_clk);
    {o_cs_n, o_rd_n, o_wr_n, o_ps, o_data} <= {1'b0, !rd, rd, ps, rd ? ~o_data : d};
    repeat (2) @(posedge i_clk);
    {o_cs_n, o_rd_n, o_wr_n, o_data} <= {3'h7, ~o_data};
    repeat (2) @(posedge i_clk);
  endtask
endmodule // uhp_host_model
`default_nettype wire

/* dv/uhp_port_monitor.sv */
/* Pin checker of uhp_port. Sees only the top module's ports and is bound below. */
`timescale 1ns/1ps
`default_nettype none
module uhp_port_monitor (
  input wire logic       I_CLK_SYS, I_RST, I_DEVICE_RESET_N, I_CHIP_SELECT_N, I_READ_STROBE_N,
  input wire logic       I_ROLE_STRAP, I_CLOCK_MULTIPLY_SELECT, I_DMA_ACK_N, O_DATA_OE, O_IRQ_OUT,
  input wire logic       O_DMA_REQ_N, O_SLAVE_MODE, O_CLK_12M_SRC,
  input wire logic [6:0] I_EVENTS
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST || !I_DEVICE_RESET_N);
  sequence s_rd; !I_CHIP_SELECT_N && !I_READ_STROBE_N; endsequence
  sequence s_run; !$past(I_RST) && $past(I_DEVICE_RESET_N); endsequence
  a_read_drives: assert property (s_rd |=> O_DATA_OE) else $error("read not driven");
  a_drive_only_read: assert property (O_DATA_OE |-> $past(!I_CHIP_SELECT_N && !I_READ_STROBE_N))
    else $error("stray drive");
  a_reset_quiet: assert property (disable iff (I_RST) !I_DEVICE_RESET_N |=> !O_DATA_OE && !O_IRQ_OUT
    && O_DMA_REQ_N && !O_SLAVE_MODE) else $error("reset leak");
  a_role_copy: assert property (s_run |-> O_SLAVE_MODE == $past(I_ROLE_STRAP)) else $error("role");
  a_mult_copy: assert property (s_run |-> O_CLK_12M_SRC == $past(I_CLOCK_MULTIPLY_SELECT)) else $error("mult");
  a_req_slave: assert property (!O_DMA_REQ_N |-> O_SLAVE_MODE) else $error("master request");
  a_req_ack_high: assert property (!O_DMA_REQ_N |-> $past(I_DMA_ACK_N)) else $error("request in ack");
  a_irq_raise: assert property (I_EVENTS != 7'h00 |-> ##[1:2] O_IRQ_OUT) else $error("irq missing");
endmodule // uhp_port_monitor
bind uhp_port uhp_port_monitor mon (.I_CLK_SYS, .I_RST, .I_DEVICE_RESET_N, .I_CHIP_SELECT_N, .I_READ_STROBE_N,
  .I_ROLE_STRAP, .I_CLOCK_MULTIPLY_SELECT, .I_DMA_ACK_N, .O_DATA_OE, .O_IRQ_OUT, .O_DMA_REQ_N, .O_SLAVE_MODE,
  .O_CLK_12M_SRC, .I_EVENTS);
`default_nettype wire

/* src/uhp_pkg.sv */
/*
  Constants of the host bus port: widths, memory size and the fixed locations it uses.
  Assumes a single 100 MHz system clock.
*/
package uhp_pkg;

  localparam int unsigned        DATA_W        = 8;
  localparam int unsigned        MEM_DEPTH     = 256;
  localparam logic [7:0]         INT_STAT_ADDR = 8'h0d;
  localparam logic [7:0]         CTRL1_ADDR    = 8'h05;
  localparam logic [7:0]         DMA_CNT_LO    = 8'h35;
  localparam logic [7:0]         DMA_CNT_HI    = 8'h36;
  localparam int unsigned        CTRL1_DMA_EN  = 1;
  localparam int unsigned        IST_DMA_BUSY  = 7;
  localparam int unsigned        IST_DMA_DONE  = 4;
  localparam logic [7:0]         ZERO_BYTE     = 8'h00;
  localparam logic [15:0]        ZERO_COUNT    = 16'h0000;
  localparam logic [15:0]        ONE_COUNT     = 16'h0001;
  localparam logic [7:0]         IST_EVT_MASK  = 8'h7f;

  typedef enum logic [2:0] {
    UHP_IDLE = 3'b001,
    UHP_ACC  = 3'b010,
    UHP_WAIT = 3'b100
  } uhp_state_t;

endpackage : uhp_pkg

/* src/uhp_port.sv */
/*
  Pin-level microprocessor port: pointer latch, register and buffer memory, interrupt flags and DMA handshake.
  Assumes all pin inputs are synchronous to I_CLK_SYS and that engine events arrive as one-cycle pulses.
*/
// Summary of operation
// (RULE_01) Write on write strobe with chip select.
// (RULE_02) Drive selected location on read strobe.
// (RULE_03) Port select 0 pointer, 1 data location.
// (RULE_04) Shared eight-bit bus, driven only reading.
// (RULE_05) Interrupt output high while flags pending.
// (RULE_06) Device held reset while reset pin low.
// (RULE_07) Role strap: 1 slave, 0 master.
// (RULE_08) Board ties multiply strap per source.
// (RULE_09) Active-low DMA request and acknowledge handshake.
// (RULE_10) DMA requests only in slave operation.
// (RULE_11) Host mode: acknowledge high, request open.
// (RULE_12) Status write one clears, zero keeps.
// (RULE_13) Low count first; high write starts DMA.
// (RULE_14) Pointer latched; data accesses use it.
`timescale 1ns/1ps
`default_nettype none
module uhp_port
  import uhp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  // Device pins.
  input  wire logic              I_DEVICE_RESET_N,
  input  wire logic              I_CHIP_SELECT_N,
  input  wire logic              I_READ_STROBE_N,
  input  wire logic              I_WRITE_STROBE_N,
  input  wire logic              I_PORT_SELECT,
  input  wire logic [7:0]        I_DATA,
  output logic      [7:0]        O_DATA,
  output logic                   O_DATA_OE,
  output logic                   O_IRQ_OUT,
  input  wire logic              I_ROLE_STRAP,
  input  wire logic              I_CLOCK_MULTIPLY_SELECT,
  input  wire logic              I_DMA_ACK_N,
  output logic                   O_DMA_REQ_N,
  // Engine side.
  input  wire logic [6:0]        I_EVENTS,
  output logic                   O_SLAVE_MODE,
  output logic                   O_CLK_12M_SRC
);

  logic             rst;
  logic [7:0]       ptr_r;
  logic [7:0]       mem_r [MEM_DEPTH];
  logic [6:0]       flags_r;
  logic [15:0]      dma_cnt_r;
  logic             dma_busy_r;
  logic             dma_done_ev;
  logic             ack_d_r;
  uhp_state_t       state_r;
  logic             cs_rd;
  logic             cs_wr;
  logic             wr_start;
  logic             wr_data;
  logic             wr_ist;
  logic [7:0]       rd_byte;

  assign rst      = I_RST | ~I_DEVICE_RESET_N;  // see (RULE_06)
  assign cs_rd    = ~I_CHIP_SELECT_N & ~I_READ_STROBE_N;  // see (RULE_02)
  assign cs_wr    = ~I_CHIP_SELECT_N & ~I_WRITE_STROBE_N;  // see (RULE_01)
  assign wr_start = cs_wr && (state_r == UHP_IDLE);
  assign wr_data  = wr_start & I_PORT_SELECT;  // see (RULE_03)
  assign wr_ist   = wr_data && (ptr_r == INT_STAT_ADDR);
  assign rd_byte  = (ptr_r == INT_STAT_ADDR) ? {dma_busy_r, flags_r} : mem_r[ptr_r];

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencer: one action per strobe pulse.
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      state_r <= UHP_IDLE;
    end else if (I_CE) begin
      unique case (state_r)
        UHP_IDLE: begin
          if (cs_wr || cs_rd) begin
            state_r <= UHP_ACC;
          end
        end
        UHP_ACC: begin
          state_r <= UHP_WAIT;
        end
        UHP_WAIT: begin
          if (!cs_wr && !cs_rd) begin
            state_r <= UHP_IDLE;
          end
        end
        default: begin
          state_r <= UHP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address pointer.
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      ptr_r <= ZERO_BYTE;
    end else if (I_CE && wr_start && !I_PORT_SELECT) begin
      ptr_r <= I_DATA;  // see (RULE_14) (RULE_03)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register and buffer memory.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_CE && wr_data && !wr_ist) begin
      mem_r[ptr_r] <= I_DATA;  // see (RULE_01) (RULE_14)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and bus drive.
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      O_DATA    <= ZERO_BYTE;
      O_DATA_OE <= 1'b0;
    end else if (I_CE) begin
      O_DATA_OE <= cs_rd;  // see (RULE_04)
      if (cs_rd && state_r == UHP_IDLE) begin
        O_DATA <= I_PORT_SELECT ? rd_byte : ptr_r;  // see (RULE_02) (RULE_03)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: set wins over clear.
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      flags_r <= 7'h00;
    end else if (I_CE) begin
      flags_r <= (flags_r & ~(wr_ist ? I_DATA[6:0] : 7'h00))  // see (RULE_12)
               | I_EVENTS[6:0]
               | {2'b00, dma_done_ev, 4'h0};
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      O_IRQ_OUT <= 1'b0;
    end else if (I_CE) begin
      O_IRQ_OUT <= |(flags_r & IST_EVT_MASK[6:0]);  // see (RULE_05)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Straps and role.
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      O_SLAVE_MODE  <= 1'b0;
      O_CLK_12M_SRC <= 1'b0;
    end else if (I_CE) begin
      O_SLAVE_MODE  <= I_ROLE_STRAP;  // see (RULE_07)
      O_CLK_12M_SRC <= I_CLOCK_MULTIPLY_SELECT;  // see (RULE_08)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA counter and handshake.
  assign dma_done_ev = dma_busy_r && !I_DMA_ACK_N && ack_d_r && (dma_cnt_r == ONE_COUNT);

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      dma_cnt_r   <= ZERO_COUNT;
      dma_busy_r  <= 1'b0;
      ack_d_r     <= 1'b1;
      O_DMA_REQ_N <= 1'b1;
    end else if (I_CE) begin
      ack_d_r <= I_DMA_ACK_N;
      if (wr_data && ptr_r == DMA_CNT_LO) begin
        dma_cnt_r[7:0] <= I_DATA;  // see (RULE_13)
      end else if (wr_data && ptr_r == DMA_CNT_HI) begin
        dma_cnt_r[15:8] <= I_DATA;
        dma_busy_r      <= mem_r[CTRL1_ADDR][CTRL1_DMA_EN] && O_SLAVE_MODE
                           && ({I_DATA, dma_cnt_r[7:0]} != ZERO_COUNT);  // see (RULE_13) (RULE_10)
      end else if (dma_busy_r && !I_DMA_ACK_N && ack_d_r) begin
        dma_cnt_r <= dma_cnt_r - ONE_COUNT;  // see (RULE_09)
        if (dma_cnt_r == ONE_COUNT) begin
          dma_busy_r <= 1'b0;
        end
      end
      O_DMA_REQ_N <= ~(dma_busy_r && O_SLAVE_MODE && I_DMA_ACK_N);  // see (RULE_09) (RULE_10) (RULE_11)
    end
  end

endmodule // uhp_port
`default_nettype wire
